// *** phy_status_led_pkg.sv ***
// shared constants for status-change reporting and indicator selection
package phy_status_led_pkg;

	// management register addresses (5-bit register space)
	localparam logic [4:0] INT_ENABLE_ADDR = 5'h12;
	localparam logic [4:0] STATUS_CHANGE_ADDR = 5'h13;
	localparam logic [4:0] INDICATOR_CFG_ADDR = 5'h14;

	// status-change field positions
	localparam int AUTONEG_DONE_BIT = 7;
	localparam int SPEED_CHG_BIT = 6;
	localparam int DUPLEX_CHG_BIT = 5;
	localparam int LINK_CHG_BIT = 4;
	localparam int IRQ_PENDING_BIT = 2;

	// interrupt enable field positions
	localparam int MASK_LSB = 4;
	localparam int IRQ_ENABLE_BIT = 1;
	localparam int IRQ_FORCE_BIT = 0;

	// indicator configuration field positions
	localparam int IND_ONE_LSB = 12;
	localparam int IND_TWO_LSB = 8;
	localparam int IND_THREE_LSB = 4;
	localparam int STRETCH_DUR_LSB = 2;
	localparam int STRETCH_EN_BIT = 1;

	// reset values
	localparam logic [3:0] IND_ONE_RESET = 4'h0;
	localparam logic [3:0] IND_TWO_RESET = 4'h4;
	localparam logic [3:0] IND_THREE_RESET = 4'h2;
	localparam logic [1:0] STRETCH_DUR_RESET = 2'h0;
	localparam logic STRETCH_EN_RESET = 1'b1;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// indicator selector codes
	localparam logic [3:0] SEL_SPEED = 4'h0;
	localparam logic [3:0] SEL_TX = 4'h1;
	localparam logic [3:0] SEL_RX = 4'h2;
	localparam logic [3:0] SEL_COL = 4'h3;
	localparam logic [3:0] SEL_LINK = 4'h4;
	localparam logic [3:0] SEL_DUPLEX = 4'h5;
	localparam logic [3:0] SEL_ACT = 4'h7;
	localparam logic [3:0] SEL_FORCE_ON = 4'h8;
	localparam logic [3:0] SEL_FORCE_OFF = 4'h9;
	localparam logic [3:0] SEL_BLINK_FAST = 4'ha;
	localparam logic [3:0] SEL_BLINK_SLOW = 4'hb;
	localparam logic [3:0] SEL_LINK_RX = 4'hc;
	localparam logic [3:0] SEL_LINK_ACT = 4'hd;
	localparam logic [3:0] SEL_DUPLEX_COL = 4'he;

	// stretch duration codes
	localparam logic [1:0] DUR_30 = 2'h0;
	localparam logic [1:0] DUR_60 = 2'h1;
	localparam logic [1:0] DUR_100 = 2'h2;

	// timing: clock period and stretch/blink times
	localparam int CLK_PERIOD_NS = 10;
	localparam int STRETCH_30_MS = 30;
	localparam int STRETCH_60_MS = 60;
	localparam int STRETCH_100_MS = 100;
	localparam int BLINK_FAST_HALF_MS = 50;
	localparam int BLINK_SLOW_HALF_MS = 250;
	localparam int STRETCH_30_CYC = STRETCH_30_MS * 1000000 / CLK_PERIOD_NS;
	localparam int STRETCH_60_CYC = STRETCH_60_MS * 1000000 / CLK_PERIOD_NS;
	localparam int STRETCH_100_CYC = STRETCH_100_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BLINK_FAST_CYC = BLINK_FAST_HALF_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BLINK_SLOW_CYC = BLINK_SLOW_HALF_MS * 1000000 / CLK_PERIOD_NS;

	localparam int CNT_W = 32;

endpackage : phy_status_led_pkg

// *** indicator_driver.sv ***
// one indicator driver: selector decode, pulse stretching, output flop
`timescale 1ns/1ps
module indicator_driver (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// configuration
	input wire logic [3:0] select_i,
	input wire logic stretch_en_i,
	input wire logic [31:0] stretch_cycles_i,
	// line status
	input wire logic speed_100_i,
	input wire logic link_up_i,
	input wire logic full_duplex_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	input wire logic collision_i,
	// shared blink references
	input wire logic blink_fast_i,
	input wire logic blink_slow_i,
	// indicator output, high = lit
	output logic led_o
);

	typedef struct packed {
		logic [31:0] tx_cnt;
		logic [31:0] rx_cnt;
		logic [31:0] col_cnt;
		logic led;
	} state_s;

	state_s state_q;
	state_s state_d;
	logic tx_str;
	logic rx_str;
	logic col_str;

	// stretched views hold each event for the programmed time after it ends
	assign tx_str = tx_active_i || (state_q.tx_cnt != '0);
	assign rx_str = rx_active_i || (state_q.rx_cnt != '0);
	assign col_str = collision_i || (state_q.col_cnt != '0);

	// reload on event, count down otherwise; combined codes always use these
	always_comb begin
		state_d = state_q;
		state_d.tx_cnt = tx_active_i ? stretch_cycles_i :
			(state_q.tx_cnt != '0 ? state_q.tx_cnt - 32'h1 : '0);
		state_d.rx_cnt = rx_active_i ? stretch_cycles_i :
			(state_q.rx_cnt != '0 ? state_q.rx_cnt - 32'h1 : '0);
		state_d.col_cnt = collision_i ? stretch_cycles_i :
			(state_q.col_cnt != '0 ? state_q.col_cnt - 32'h1 : '0);
		unique case (select_i)
			phy_status_led_pkg::SEL_SPEED: state_d.led = speed_100_i;
			phy_status_led_pkg::SEL_TX: state_d.led = stretch_en_i ? tx_str : tx_active_i;
			phy_status_led_pkg::SEL_RX: state_d.led = stretch_en_i ? rx_str : rx_active_i;
			phy_status_led_pkg::SEL_COL: state_d.led = stretch_en_i ? col_str : collision_i;
			phy_status_led_pkg::SEL_LINK: state_d.led = link_up_i;
			phy_status_led_pkg::SEL_DUPLEX: state_d.led = full_duplex_i;
			phy_status_led_pkg::SEL_ACT: state_d.led = stretch_en_i ? (tx_str || rx_str) :
				(tx_active_i || rx_active_i);
			phy_status_led_pkg::SEL_FORCE_ON: state_d.led = 1'b1;
			phy_status_led_pkg::SEL_FORCE_OFF: state_d.led = 1'b0;
			phy_status_led_pkg::SEL_BLINK_FAST: state_d.led = blink_fast_i;
			phy_status_led_pkg::SEL_BLINK_SLOW: state_d.led = blink_slow_i;
			phy_status_led_pkg::SEL_LINK_RX: state_d.led = link_up_i ^ (rx_str && blink_fast_i);
			phy_status_led_pkg::SEL_LINK_ACT: state_d.led =
				link_up_i ^ ((tx_str || rx_str) && blink_fast_i);
			phy_status_led_pkg::SEL_DUPLEX_COL: state_d.led =
				full_duplex_i ^ (col_str && blink_fast_i);
			// unused encodings leave the indicator dark
			default: state_d.led = 1'b0;
		endcase
	end

	// single state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign led_o = state_q.led;

endmodule : indicator_driver

// *** phy_status_led.sv ***
// status-change register, interrupt mask and indicator configuration
//
// Overview of operation
// - bit 7 shows auto-negotiation done
// - bit 6 speed changed, cleared on read
// - bit 5 duplex changed, cleared on read
// - bit 4 link changed, resets zero
// - bit 2 shows interrupt pending
// - code 0000 shows speed, default one
// - codes 1-3 show tx, rx, collision stretched
// - code 0100 shows link, default two
// - code 0101 shows duplex, continuous
// - code 0111 shows activity, stretched
// - codes 8-b force on, off, blink
// - code 1100 link solid, rx blinks
// - code 1101 link solid, activity blinks
// - code 1110 duplex solid, collision blinks
// - combined codes stretch regardless of enable
// - duration field picks 30, 60, 100 ms
// - stretch enable bit, resets to one
// - masked events raise management interrupt
`timescale 1ns/1ps
module phy_status_led #(
	parameter int unsigned STRETCH_30_CYC = phy_status_led_pkg::STRETCH_30_CYC,
	parameter int unsigned STRETCH_60_CYC = phy_status_led_pkg::STRETCH_60_CYC,
	parameter int unsigned STRETCH_100_CYC = phy_status_led_pkg::STRETCH_100_CYC,
	parameter int unsigned BLINK_FAST_CYC = phy_status_led_pkg::BLINK_FAST_CYC,
	parameter int unsigned BLINK_SLOW_CYC = phy_status_led_pkg::BLINK_SLOW_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// management register port from the serial frame decoder
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// line status from the PHY core
	input wire logic autoneg_done_i,
	input wire logic speed_100_i,
	input wire logic full_duplex_i,
	input wire logic link_up_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	input wire logic collision_i,
	// outputs
	output logic mgmt_irq_o,
	output logic [1:0] led_o
);

	typedef struct packed {
		logic an_flag;
		logic speed_flag;
		logic duplex_flag;
		logic link_flag;
		logic speed_prev;
		logic duplex_prev;
		logic link_prev;
		logic [3:0] mask;
		logic irq_en;
		logic irq_force;
		logic [3:0] ind_one;
		logic [3:0] ind_two;
		logic [3:0] ind_three;
		logic [1:0] dur;
		logic stretch_en;
		logic irq;
		logic [15:0] rdata;
		logic [31:0] fast_cnt;
		logic [31:0] slow_cnt;
		logic blink_fast;
		logic blink_slow;
	} state_s;

	state_s state_q;
	state_s state_d;
	logic [31:0] stretch_cycles;
	logic [3:0] sel [2];

	// address match against a register, shared by read and write paths
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
		hit = (addr == target);
	endfunction : hit

	// assemble the status-change word from flags and pending state
	function automatic logic [15:0] status_word(input state_s s);
		logic [15:0] w;
		w = '0;
		w[phy_status_led_pkg::AUTONEG_DONE_BIT] = s.an_flag;
		w[phy_status_led_pkg::SPEED_CHG_BIT] = s.speed_flag;
		w[phy_status_led_pkg::DUPLEX_CHG_BIT] = s.duplex_flag;
		w[phy_status_led_pkg::LINK_CHG_BIT] = s.link_flag;
		w[phy_status_led_pkg::IRQ_PENDING_BIT] = s.irq;
		return w;
	endfunction : status_word

	always_comb begin
		unique case (state_q.dur)
			phy_status_led_pkg::DUR_60: stretch_cycles = STRETCH_60_CYC;
			phy_status_led_pkg::DUR_100: stretch_cycles = STRETCH_100_CYC;
			// reserved code falls back to the shortest time
			default: stretch_cycles = STRETCH_30_CYC;
		endcase
	end

	assign sel[0] = state_q.ind_one;
	assign sel[1] = state_q.ind_two;

	// next-state logic for flags, registers, read data and blink references
	always_comb begin
		logic rd_status;
		logic [3:0] pend;
		rd_status = reg_rd_i && hit(reg_addr_i, phy_status_led_pkg::STATUS_CHANGE_ADDR);
		pend = {state_q.an_flag, state_q.speed_flag, state_q.duplex_flag, state_q.link_flag}
			& state_q.mask;
		state_d = state_q;
		state_d.speed_prev = speed_100_i;
		state_d.duplex_prev = full_duplex_i;
		state_d.link_prev = link_up_i;
		state_d.an_flag = (state_q.an_flag && !rd_status) || autoneg_done_i;
		state_d.speed_flag = (state_q.speed_flag && !rd_status) ||
			(speed_100_i != state_q.speed_prev);
		state_d.duplex_flag = (state_q.duplex_flag && !rd_status) ||
			(full_duplex_i != state_q.duplex_prev);
		state_d.link_flag = (state_q.link_flag && !rd_status) ||
			(link_up_i != state_q.link_prev);
		state_d.irq = state_q.irq_en && ((|pend) || state_q.irq_force);
		// register writes
		if (reg_wr_i && hit(reg_addr_i, phy_status_led_pkg::INT_ENABLE_ADDR)) begin
			state_d.mask = reg_wdata_i[phy_status_led_pkg::MASK_LSB +: 4];
			state_d.irq_en = reg_wdata_i[phy_status_led_pkg::IRQ_ENABLE_BIT];
			state_d.irq_force = reg_wdata_i[phy_status_led_pkg::IRQ_FORCE_BIT];
		end
		if (reg_wr_i && hit(reg_addr_i, phy_status_led_pkg::INDICATOR_CFG_ADDR)) begin
			state_d.ind_one = reg_wdata_i[phy_status_led_pkg::IND_ONE_LSB +: 4];
			state_d.ind_two = reg_wdata_i[phy_status_led_pkg::IND_TWO_LSB +: 4];
			state_d.ind_three = reg_wdata_i[phy_status_led_pkg::IND_THREE_LSB +: 4];
			state_d.dur = reg_wdata_i[phy_status_led_pkg::STRETCH_DUR_LSB +: 2];
			state_d.stretch_en = reg_wdata_i[phy_status_led_pkg::STRETCH_EN_BIT];
		end
		// read data is captured on the read strobe; unmapped reads return zero
		if (reg_rd_i) begin
			state_d.rdata = '0;
			if (rd_status) begin
				state_d.rdata = status_word(state_q);
			end else if (hit(reg_addr_i, phy_status_led_pkg::INT_ENABLE_ADDR)) begin
				state_d.rdata[phy_status_led_pkg::MASK_LSB +: 4] = state_q.mask;
				state_d.rdata[phy_status_led_pkg::IRQ_ENABLE_BIT] = state_q.irq_en;
				state_d.rdata[phy_status_led_pkg::IRQ_FORCE_BIT] = state_q.irq_force;
			end else if (hit(reg_addr_i, phy_status_led_pkg::INDICATOR_CFG_ADDR)) begin
				state_d.rdata[phy_status_led_pkg::IND_ONE_LSB +: 4] = state_q.ind_one;
				state_d.rdata[phy_status_led_pkg::IND_TWO_LSB +: 4] = state_q.ind_two;
				state_d.rdata[phy_status_led_pkg::IND_THREE_LSB +: 4] = state_q.ind_three;
				state_d.rdata[phy_status_led_pkg::STRETCH_DUR_LSB +: 2] = state_q.dur;
				state_d.rdata[phy_status_led_pkg::STRETCH_EN_BIT] = state_q.stretch_en;
			end
		end
		if (state_q.fast_cnt >= BLINK_FAST_CYC - 1) begin
			state_d.fast_cnt = '0;
			state_d.blink_fast = !state_q.blink_fast;
		end else begin
			state_d.fast_cnt = state_q.fast_cnt + 32'h1;
		end
		if (state_q.slow_cnt >= BLINK_SLOW_CYC - 1) begin
			state_d.slow_cnt = '0;
			state_d.blink_slow = !state_q.blink_slow;
		end else begin
			state_d.slow_cnt = state_q.slow_cnt + 32'h1;
		end
	end

	// single state register; reset values set the documented defaults
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= '0;
			state_q.mask <= phy_status_led_pkg::MASK_RESET;
			state_q.ind_one <= phy_status_led_pkg::IND_ONE_RESET;
			state_q.ind_two <= phy_status_led_pkg::IND_TWO_RESET;
			state_q.ind_three <= phy_status_led_pkg::IND_THREE_RESET;
			state_q.dur <= phy_status_led_pkg::STRETCH_DUR_RESET;
			state_q.stretch_en <= phy_status_led_pkg::STRETCH_EN_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// indicator drivers share blink references and stretch time
	for (genvar i = 0; i < 2; i++) begin : g_ind
		indicator_driver u_ind (
			.clk_i(clk_i),
			.rstn_i(rstn_i),
			.select_i(sel[i]),
			.stretch_en_i(state_q.stretch_en),
			.stretch_cycles_i(stretch_cycles),
			.speed_100_i(speed_100_i),
			.link_up_i(link_up_i),
			.full_duplex_i(full_duplex_i),
			.tx_active_i(tx_active_i),
			.rx_active_i(rx_active_i),
			.collision_i(collision_i),
			.blink_fast_i(state_q.blink_fast),
			.blink_slow_i(state_q.blink_slow),
			.led_o(led_o[i])
		);
	end

	assign reg_rdata_o = state_q.rdata;
	assign mgmt_irq_o = state_q.irq;

endmodule : phy_status_led

// *** phy_status_led_properties.sv ***
// assertion checker for the status-change and indicator block
`timescale 1ns/1ps
module phy_status_led_properties (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// register port
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	// line status and outputs
	input wire logic autoneg_done_i,
	input wire logic speed_100_i,
	input wire logic full_duplex_i,
	input wire logic link_up_i,
	input wire logic mgmt_irq_o,
	input wire logic [1:0] led_o
);
	logic [3:0] sel_one_q;
	logic [3:0] sel_two_q;
	logic irq_en_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// mirror of live selector and enable fields, so led checks know the code
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_one_q <= phy_status_led_pkg::IND_ONE_RESET;
			sel_two_q <= phy_status_led_pkg::IND_TWO_RESET;
			irq_en_q <= 1'b0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 5'h14) begin
				sel_one_q <= reg_wdata_i[15:12];
				sel_two_q <= reg_wdata_i[11:8];
			end
			if (reg_addr_i == 5'h12) begin
				irq_en_q <= reg_wdata_i[1];
			end
		end
	end
	// read strobe aimed at the status-change word
	sequence rd_stat_s;
		reg_rd_i && reg_addr_i == 5'h13;
	endsequence
	an_done_a: assert property (autoneg_done_i [*2] ##0 rd_stat_s |=> reg_rdata_o[7])
		else $error("autoneg done bit low");
	speed_flag_a: assert property ($changed(speed_100_i) ##1 rd_stat_s |=> reg_rdata_o[6])
		else $error("speed change flag missing");
	duplex_flag_a: assert property ($changed(full_duplex_i) ##1 rd_stat_s |=> reg_rdata_o[5])
		else $error("duplex change flag missing");
	link_flag_a: assert property ($changed(link_up_i) ##1 rd_stat_s |=> reg_rdata_o[4])
		else $error("link change flag lost");
	clear_read_a: assert property (rd_stat_s ##0 $stable(link_up_i) ##1 rd_stat_s |=> !reg_rdata_o[4])
		else $error("link flag not cleared by read");
	irq_bit_a: assert property (rd_stat_s |=> reg_rdata_o[2] == $past(mgmt_irq_o))
		else $error("pending bit differs from interrupt");
	irq_gate_a: assert property (!irq_en_q [*2] |-> !mgmt_irq_o)
		else $error("interrupt raised while disabled");
	speed_led_a: assert property (sel_one_q == 4'h0 |=> led_o[0] == $past(speed_100_i))
		else $error("indicator one not showing speed");
	link_led_a: assert property (sel_two_q == 4'h4 |=> led_o[1] == $past(link_up_i))
		else $error("indicator two not showing link");
	duplex_led_a: assert property (sel_one_q == 4'h5 |=> led_o[0] == $past(full_duplex_i))
		else $error("indicator one not showing duplex");
	force_led_a: assert property (sel_one_q == 4'h8 ##0 sel_two_q == 4'h9 |=> led_o == 2'b01)
		else $error("forced indicator levels wrong");
endmodule : phy_status_led_properties

bind phy_status_led phy_status_led_properties phy_status_led_properties_i (.clk_i, .rstn_i,
	.reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .autoneg_done_i,
	.speed_100_i, .full_duplex_i, .link_up_i, .mgmt_irq_o, .led_o);

// *** mgmt_host_model.sv ***
// management host model: drives register strobes, queues expected read words
`timescale 1ns/1ps
module mgmt_host_model (
	// clock
	input wire logic clk_i,
	// register port toward the block
	output logic [4:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [15:0] reg_wdata_o
);
	logic [15:0] exp_q[$];
	initial begin
		reg_addr_o = 5'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 16'h0000;
	end
	// one write; released lines show the inverse so stale data never looks valid
	task wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~d;
		@(posedge clk_i);
	endtask : wr
	// n back-to-back reads; the idle edge after keeps strobes from double driving
	task rd(input logic [4:0] a, input logic [15:0] e0, input logic [15:0] e1, input int n);
		exp_q.push_back(e0);
		if (n > 1) begin
			exp_q.push_back(e1);
		end
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		@(posedge clk_i);
	endtask : rd
endmodule : mgmt_host_model

// *** phy_status_led_bench.sv ***
// self-checking bench for the status-change and indicator block
`timescale 1ns/1ps
module phy_status_led_bench;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [4:0] reg_addr_i;
	logic reg_wr_i, reg_rd_i, rd_d = 1'b0;
	logic [15:0] reg_wdata_i, reg_rdata_o, d;
	logic autoneg_done_i = 1'b0, speed_100_i = 1'b0, full_duplex_i = 1'b0, link_up_i = 1'b0;
	logic tx_active_i = 1'b0, rx_active_i = 1'b0, collision_i = 1'b0, mgmt_irq_o;
	logic [1:0] led_o;
	int err_total = 0, n_checks = 0, zeros, zeros_two, tgl_fast, tgl_slow;
	logic [1:0] led_prev;
	// lit codes with speed, link and duplex up and no traffic
	localparam logic [15:0] led_tbl = 16'h7131;
	phy_status_led #(.STRETCH_30_CYC(30), .STRETCH_60_CYC(60), .STRETCH_100_CYC(100),
		.BLINK_FAST_CYC(4), .BLINK_SLOW_CYC(10)) phy_status_led_i (.clk_i, .rstn_i,
		.reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .autoneg_done_i,
		.speed_100_i, .full_duplex_i, .link_up_i, .tx_active_i, .rx_active_i, .collision_i,
		.mgmt_irq_o, .led_o);
	mgmt_host_model mgmt_host_model_i (.clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test
	// read words are compared mid-cycle, clear of the edge that updates them
	always @(posedge clk_i) rd_d <= reg_rd_i;
	always @(negedge clk_i) begin
		if (rd_d && rstn_i) check(reg_rdata_o, mgmt_host_model_i.exp_q.pop_front());
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (5000) @(posedge clk_i);
		err_total++;
		stop_test();
	end
	initial begin
		void'($urandom(97456));
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		mgmt_host_model_i.rd(5'h14, 16'h0422, 16'h0, 1);
		mgmt_host_model_i.rd(5'h1f, 16'h0000, 16'h0, 1);
		{autoneg_done_i, speed_100_i, full_duplex_i, link_up_i} <= 4'hf;
		repeat (3) @(posedge clk_i);
		mgmt_host_model_i.rd(5'h13, 16'h00f0, 16'h0080, 2);
		link_up_i <= 1'b0;
		mgmt_host_model_i.rd(5'h13, 16'h0080, 16'h0090, 2);
		// masked link event, then forced interrupt
		mgmt_host_model_i.wr(5'h12, 16'h0012);
		link_up_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check({15'h0, mgmt_irq_o}, 16'h0001);
		mgmt_host_model_i.rd(5'h13, 16'h0094, 16'h0, 1);
		repeat (3) @(posedge clk_i);
		check({15'h0, mgmt_irq_o}, 16'h0000);
		mgmt_host_model_i.wr(5'h12, 16'h0003);
		repeat (2) @(posedge clk_i);
		check({15'h0, mgmt_irq_o}, 16'h0001);
		mgmt_host_model_i.wr(5'h12, 16'h0000);
		for (int c = 0; c < 15; c++) begin
			if (c == 6 || c == 10 || c == 11) continue;
			mgmt_host_model_i.wr(5'h14, {c[3:0], c[3:0], 8'h00});
			repeat (2) @(posedge clk_i);
			check({14'h0, led_o}, {14'h0, {2{led_tbl[c]}}});
		end
		// blink references: half periods of 4 and 10 cycles as set above
		mgmt_host_model_i.wr(5'h14, 16'hab00);
		tgl_fast = 0;
		tgl_slow = 0;
		@(negedge clk_i);
		led_prev = led_o;
		repeat (40) begin
			@(negedge clk_i);
			tgl_fast += (led_o[0] != led_prev[0]);
			tgl_slow += (led_o[1] != led_prev[1]);
			led_prev = led_o;
		end
		check(tgl_fast[15:0], 16'h000a);
		check(tgl_slow[15:0], 16'h0004);
		// random low field must read back, reserved bit dropped
		d = 16'($urandom());
		d[15:8] = 8'h89;
		mgmt_host_model_i.wr(5'h14, d);
		mgmt_host_model_i.rd(5'h14, d & 16'hfffe, 16'h0, 1);
		check({14'h0, led_o}, 16'h0001);
		// transmit event stretched to 60 cycles
		mgmt_host_model_i.wr(5'h14, 16'h1006);
		tx_active_i <= 1'b1;
		@(posedge clk_i);
		tx_active_i <= 1'b0;
		repeat (45) @(posedge clk_i);
		check({15'h0, led_o[0]}, 16'h0001);
		repeat (30) @(posedge clk_i);
		check({15'h0, led_o[0]}, 16'h0000);
		// combined code still blinks with stretching disabled
		// link-rx and duplex-collision codes blink on their events
		for (int k = 0; k < 2; k++) begin
			mgmt_host_model_i.wr(5'h14, k ? 16'hce00 : 16'hde00);
			rx_active_i <= 1'b1;
			collision_i <= 1'b1;
			@(posedge clk_i);
			rx_active_i <= 1'b0;
			collision_i <= 1'b0;
			zeros = 0;
			zeros_two = 0;
			repeat (20) begin
				@(negedge clk_i);
				zeros += (led_o[0] === 1'b0);
				zeros_two += (led_o[1] === 1'b0);
			end
			check({15'h0, zeros != 0}, 16'h0001);
			check({15'h0, zeros_two != 0}, 16'h0001);
		end
		// completion bit is cleared by a read once the input drops
		autoneg_done_i <= 1'b0;
		mgmt_host_model_i.rd(5'h13, 16'h0080, 16'h0000, 2);
		stop_test();
	end
endmodule : phy_status_led_bench
